// *** multilink_reset_control_regs.svh ***
`ifndef MULTILINK_RESET_CONTROL_REGS_SVH
`define MULTILINK_RESET_CONTROL_REGS_SVH

// sequence arithmetic is modulo 4096
`define SEQ_W        12
`define SEQ_MODULUS  4096
`define SEQ_ZERO     12'h000
`define LINK_W       2
`define NUM_LINKS    4
`define WINDOW_SIZE  12'h008
`define TMR_W        32
`define CLK_KHZ      20000
`define RST_TMO_MS   100
`define RST_TMO_CYC  (`RST_TMO_MS * `CLK_KHZ)

`endif

// *** multilink_reset_control_pkg.sv ***
package multilink_reset_control_pkg;
`include "multilink_reset_control_regs.svh"

	// two-octet control field as carried in each frame
	typedef struct packed {
		logic [`SEQ_W-1:0] frameSeqNumber;
		logic              voidSeq;
		logic              seqCheck;
		logic              rstReq;
		logic              rstCfm;
	} ctl_field_t;

	typedef struct packed {
		logic [`LINK_W-1:0] link;
		ctl_field_t         ctl;
	} tx_frame_t;

	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_SEND_REQ,
		ST_WAIT_PEER,
		ST_SEND_CFM,
		ST_WAIT_DONE
	} rst_state_t;

	typedef struct packed {
		rst_state_t         state;
		logic [`SEQ_W-1:0]  sendSeqState;
		logic [`SEQ_W-1:0]  oldestUnackedState;
		logic [`SEQ_W-1:0]  receiveSeqState;
		tx_frame_t          txFrame;
		logic               txValid;
		logic               pktReady;
		logic               peerReqSeen;
		logic               reqHanded;
		logic               reqXferDone;
		logic [`LINK_W-1:0] reqLink;
		logic               cfmSent;
		logic               cfmDone;
		logic               peerCfmSeen;
		logic [`LINK_W-1:0] nextLink;
		logic               timerOn;
		logic [`TMR_W-1:0]  timer;
		logic               rxDeliver;
		logic               rxDiscard;
		logic               withdrawAll;
		logic               flushRx;
		logic               resetDone;
		logic               resetActive;
	} ctl_state_t;

endpackage : multilink_reset_control_pkg

// *** multilink_reset_control.sv ***
`timescale 1ns/1ps
`include "multilink_reset_control_regs.svh"

module multilink_reset_control #(
	parameter int unsigned RST_TMO_CYCLES = `RST_TMO_CYC
) (
	input  wire logic                                       clk,
	input  wire logic                                       rst_n,
	input  wire logic                                       startReset,
	input  wire logic                                       pktValid,
	output logic                                            pktReady,
	output multilink_reset_control_pkg::tx_frame_t          txFrame,
	output logic                                            txValid,
	input  wire logic                                       txTaken,
	input  wire logic                                       reqXferInd,
	input  wire logic                                       cfmXferInd,
	input  wire logic [`LINK_W-1:0]                         cfmXferLink,
	input  wire logic                                       ackValid,
	input  wire logic [`SEQ_W-1:0]                          ackOldest,
	input  wire logic [`NUM_LINKS-1:0]                      linkUp,
	input  wire logic [`NUM_LINKS-1:0]                      linkBusy,
	input  wire logic                                       rxValid,
	input  wire multilink_reset_control_pkg::ctl_field_t    rxCtl,
	output logic                                            rxDeliver,
	output logic                                            rxDiscard,
	output logic                                            withdrawAll,
	output logic                                            flushRx,
	output logic                                            resetActive,
	output logic                                            resetDone,
	output logic [`SEQ_W-1:0]                               sendSeqState,
	output logic [`SEQ_W-1:0]                               oldestUnackedState,
	output logic [`SEQ_W-1:0]                               receiveSeqState
);

	multilink_reset_control_pkg::ctl_state_t st_ff;
	multilink_reset_control_pkg::ctl_state_t nxt_st;
	logic [`NUM_LINKS-1:0]                   linkAvail;
	logic                                    pickFound;
	logic [`LINK_W-1:0]                      pickIdx;

	assign linkAvail = linkUp & ~linkBusy;

	// round-robin search from the preferred link; failed or busy links are skipped
	always_comb begin
		logic [`LINK_W-1:0] cand;
		cand      = '0;
		pickFound = 1'b0;
		pickIdx   = st_ff.nextLink;
		for (int i = `NUM_LINKS - 1; i >= 0; i--) begin
			cand = `LINK_W'(st_ff.nextLink + `LINK_W'(i));
			if (linkAvail[cand]) begin
				pickFound = 1'b1;
				pickIdx   = cand;
			end
		end
	end

	// control field builder; void and check bits are always cleared
	function automatic multilink_reset_control_pkg::ctl_field_t mkCtl(
		input logic [`SEQ_W-1:0] seq,
		input logic              req,
		input logic              cfm
	);
		multilink_reset_control_pkg::ctl_field_t c;
		c.frameSeqNumber = seq;
		c.voidSeq        = 1'b0;
		c.seqCheck       = 1'b0;
		c.rstReq         = req;
		c.rstCfm         = cfm;
		return c;
	endfunction : mkCtl

	// all next-state logic
	always_comb begin
		logic startRst;
		logic peerReqNow;
		logic inReset;
		logic winOk;
		logic reqHandNow;
		logic cfmHandNow;
		startRst   = 1'b0;
		peerReqNow = 1'b0;
		inReset    = (st_ff.state != multilink_reset_control_pkg::ST_NORMAL);
		winOk      = (`SEQ_W'(st_ff.sendSeqState - st_ff.oldestUnackedState)
			< `WINDOW_SIZE);
		// a channel may confirm transfer in the very cycle it takes the frame
		reqHandNow = st_ff.txValid && txTaken && st_ff.txFrame.ctl.rstReq;
		cfmHandNow = st_ff.txValid && txTaken && st_ff.txFrame.ctl.rstCfm;
		nxt_st             = st_ff;
		nxt_st.rxDeliver   = 1'b0;
		nxt_st.rxDiscard   = 1'b0;
		nxt_st.withdrawAll = 1'b0;
		nxt_st.flushRx     = 1'b0;
		nxt_st.resetDone   = 1'b0;

		// handoff of the pending frame to its channel
		if (st_ff.txValid && txTaken) begin
			nxt_st.txValid  = 1'b0;
			nxt_st.nextLink = `LINK_W'(st_ff.txFrame.link + `LINK_W'(1));
			if (st_ff.txFrame.ctl.rstReq) begin
				nxt_st.reqHanded          = 1'b1;
				nxt_st.reqLink            = st_ff.txFrame.link;
				nxt_st.sendSeqState       = `SEQ_ZERO;
				nxt_st.oldestUnackedState = `SEQ_ZERO;
				nxt_st.timerOn            = 1'b1;
				nxt_st.timer              = '0;
				nxt_st.state              = multilink_reset_control_pkg::ST_WAIT_PEER;
			end
			if (st_ff.txFrame.ctl.rstCfm) begin
				nxt_st.cfmSent = 1'b1;
				nxt_st.state   = multilink_reset_control_pkg::ST_WAIT_DONE;
			end
		end else if (st_ff.txValid && !linkAvail[st_ff.txFrame.link] && pickFound) begin
			// a normal or request frame moves off a failed or busy link; the confirm is kept
			// on its link so the same-channel shortcut stays valid
			if (!st_ff.txFrame.ctl.rstCfm)
				nxt_st.txFrame.link = pickIdx;
		end

		// acknowledgement indications advance the oldest unacked frame
		if (ackValid && !inReset)
			nxt_st.oldestUnackedState = ackOldest;

		// transfer indications from the channels
		if (reqXferInd && (st_ff.reqHanded || reqHandNow))
			nxt_st.reqXferDone = 1'b1;
		if (cfmXferInd && (st_ff.cfmSent || cfmHandNow)) begin
			nxt_st.cfmDone  = 1'b1;
			nxt_st.nextLink = cfmXferLink;
		end

		// receive side; sequence field of control frames is never looked at
		if (rxValid) begin
			if (rxCtl.rstReq && rxCtl.rstCfm) begin
				nxt_st.rxDiscard = 1'b1;
			end else if (rxCtl.rstReq) begin
				if (!inReset || st_ff.cfmSent) begin
					startRst   = 1'b1;
					peerReqNow = 1'b1;
				end else if (!st_ff.peerReqSeen) begin
					peerReqNow = 1'b1;
				end else begin
					nxt_st.rxDiscard = 1'b1;
				end
			end else if (rxCtl.rstCfm) begin
				if (!inReset) begin
					nxt_st.rxDiscard = 1'b1;
				end else if (st_ff.peerReqSeen) begin
					nxt_st.peerCfmSeen = 1'b1;
					nxt_st.timerOn     = 1'b0;
				end else if (st_ff.reqHanded) begin
					// peer never saw our request: send it again
					nxt_st.state   = multilink_reset_control_pkg::ST_SEND_REQ;
					nxt_st.timerOn = 1'b0;
				end else begin
					nxt_st.rxDiscard = 1'b1;
				end
			end else if (!inReset || !st_ff.peerReqSeen) begin
				// in-order frames only; resequencing is handled elsewhere
				if (rxCtl.frameSeqNumber == st_ff.receiveSeqState) begin
					nxt_st.rxDeliver       = 1'b1;
					nxt_st.receiveSeqState = `SEQ_W'(st_ff.receiveSeqState + `SEQ_W'(1));
				end else begin
					nxt_st.rxDiscard = 1'b1;
				end
			end else begin
				nxt_st.rxDiscard = 1'b1;
			end
		end

		// supervision timer
		if (st_ff.timerOn) begin
			if (st_ff.timer >= `TMR_W'(RST_TMO_CYCLES - 1))
				startRst = 1'b1;
			else
				nxt_st.timer = `TMR_W'(st_ff.timer + `TMR_W'(1));
		end
		if (startReset && !inReset)
			startRst = 1'b1;

		// state machine for data frames and the frames issued by the reset procedure
		case (st_ff.state)
			multilink_reset_control_pkg::ST_NORMAL: begin
				if (pktValid && st_ff.pktReady && !startRst) begin
					nxt_st.txValid        = 1'b1;
					nxt_st.txFrame.link   = pickIdx;
					nxt_st.txFrame.ctl    = mkCtl(st_ff.sendSeqState, 1'b0, 1'b0);
					nxt_st.sendSeqState   = `SEQ_W'(st_ff.sendSeqState + `SEQ_W'(1));
				end
			end
			multilink_reset_control_pkg::ST_SEND_REQ: begin
				if (!st_ff.txValid && pickFound) begin
					nxt_st.txValid      = 1'b1;
					nxt_st.txFrame.link = pickIdx;
					nxt_st.txFrame.ctl  = mkCtl(`SEQ_ZERO, 1'b1, 1'b0);
				end
			end
			multilink_reset_control_pkg::ST_WAIT_PEER: begin
				if (st_ff.peerReqSeen && st_ff.reqHanded)
					nxt_st.state = multilink_reset_control_pkg::ST_SEND_CFM;
			end
			multilink_reset_control_pkg::ST_SEND_CFM: begin
				// same link may follow at once; another link needs the indication
				if (!st_ff.txValid && linkAvail[st_ff.reqLink]) begin
					nxt_st.txValid      = 1'b1;
					nxt_st.txFrame.link = st_ff.reqLink;
					nxt_st.txFrame.ctl  = mkCtl(`SEQ_ZERO, 1'b0, 1'b1);
				end else if (!st_ff.txValid && st_ff.reqXferDone && pickFound) begin
					nxt_st.txValid      = 1'b1;
					nxt_st.txFrame.link = pickIdx;
					nxt_st.txFrame.ctl  = mkCtl(`SEQ_ZERO, 1'b0, 1'b1);
				end
			end
			multilink_reset_control_pkg::ST_WAIT_DONE: begin
				if (st_ff.cfmDone && st_ff.peerCfmSeen) begin
					nxt_st.state     = multilink_reset_control_pkg::ST_NORMAL;
					nxt_st.resetDone = 1'b1;
				end
			end
			default: nxt_st.state = multilink_reset_control_pkg::ST_NORMAL;
		endcase

		// reset start: withdraw, clear send side, request again
		if (startRst) begin
			nxt_st.state              = multilink_reset_control_pkg::ST_SEND_REQ;
			nxt_st.withdrawAll        = 1'b1;
			nxt_st.txValid            = 1'b0;
			nxt_st.sendSeqState       = `SEQ_ZERO;
			nxt_st.oldestUnackedState = `SEQ_ZERO;
			nxt_st.peerReqSeen        = 1'b0;
			nxt_st.reqHanded          = 1'b0;
			nxt_st.reqXferDone        = 1'b0;
			nxt_st.cfmSent            = 1'b0;
			nxt_st.cfmDone            = 1'b0;
			nxt_st.peerCfmSeen        = 1'b0;
			nxt_st.timerOn            = 1'b0;
			nxt_st.timer              = '0;
		end
		// peer request: hand up what is held and zero the receive state in the same cycle
		if (peerReqNow) begin
			nxt_st.peerReqSeen     = 1'b1;
			nxt_st.flushRx         = 1'b1;
			nxt_st.receiveSeqState = `SEQ_ZERO;
		end

		// flow control: a slot, a window position and a usable link
		nxt_st.pktReady = (nxt_st.state == multilink_reset_control_pkg::ST_NORMAL)
			&& !nxt_st.txValid && winOk && (|linkAvail);
		// registered here so the status port comes straight from a flop
		nxt_st.resetActive = (nxt_st.state != multilink_reset_control_pkg::ST_NORMAL);
	end

	// state register; every output taken straight from here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff       <= '0;
			st_ff.state <= multilink_reset_control_pkg::ST_NORMAL;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pktReady           = st_ff.pktReady;
	assign txFrame            = st_ff.txFrame;
	assign txValid            = st_ff.txValid;
	assign rxDeliver          = st_ff.rxDeliver;
	assign rxDiscard          = st_ff.rxDiscard;
	assign withdrawAll        = st_ff.withdrawAll;
	assign flushRx            = st_ff.flushRx;
	assign resetActive        = st_ff.resetActive;
	assign resetDone          = st_ff.resetDone;
	assign sendSeqState       = st_ff.sendSeqState;
	assign oldestUnackedState = st_ff.oldestUnackedState;
	assign receiveSeqState    = st_ff.receiveSeqState;

endmodule : multilink_reset_control

// *** multilink_reset_control_properties.sv ***
`timescale 1ns/1ps
`include "multilink_reset_control_regs.svh"
module multilink_reset_control_properties (
	input wire logic	clk,
	input wire logic	rst_n,
	input wire logic	startReset,
	input wire multilink_reset_control_pkg::tx_frame_t	txFrame,
	input wire logic	txValid,
	input wire logic	rxValid,
	input wire multilink_reset_control_pkg::ctl_field_t	rxCtl,
	input wire logic	rxDeliver,
	input wire logic	rxDiscard,
	input wire logic	withdrawAll,
	input wire logic	flushRx,
	input wire logic	resetActive,
	input wire logic [`SEQ_W-1:0]	sendSeqState,
	input wire logic [`SEQ_W-1:0]	oldestUnackedState,
	input wire logic [`SEQ_W-1:0]	receiveSeqState
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// flags of frames offered to the channels
	noBothFlags_a: assert property (txValid |-> !(txFrame.ctl.rstReq && txFrame.ctl.rstCfm))
		else $error("frame offered with request and confirm set");
	resetNoNormal_a: assert property (txValid && resetActive |-> txFrame.ctl[1:0] != 2'h0)
		else $error("normal frame offered during reset");
	normalFlags_a: assert property (txValid && !resetActive |-> txFrame.ctl[3:0] == 4'h0)
		else $error("normal frame with a flag set");
	// reset start, local or from the peer
	startClear_a: assert property (startReset && !resetActive |=> withdrawAll && resetActive
		&& sendSeqState == 12'h000 && oldestUnackedState == 12'h000)
		else $error("local reset start not answered");
	peerReqRestart_a: assert property (rxValid && rxCtl[1:0] == 2'h2 && !resetActive
		|=> withdrawAll && flushRx && receiveSeqState == 12'h000)
		else $error("peer request in normal state not answered");
	// receive side judgement
	bothDiscard_a: assert property (rxValid && rxCtl[1:0] == 2'h3 |=> rxDiscard && !rxDeliver)
		else $error("frame with both flags not discarded");
	strayCfm_a: assert property (rxValid && rxCtl[3:0] == 4'h1 && !resetActive |=> rxDiscard)
		else $error("stray confirm not discarded");
	inOrder_a: assert property (rxValid && rxCtl[3:0] == 4'h0 && !resetActive
		&& rxCtl.frameSeqNumber == receiveSeqState
		|=> rxDeliver && receiveSeqState == $past(receiveSeqState) + 12'h001)
		else $error("in-order frame not delivered");
	cover property (txValid && txFrame.ctl.rstCfm);
	cover property (withdrawAll && flushRx);
	cover property (rxDeliver);
endmodule : multilink_reset_control_properties

bind multilink_reset_control multilink_reset_control_properties props (
	.clk(clk), .rst_n(rst_n), .startReset(startReset), .txFrame(txFrame), .txValid(txValid),
	.rxValid(rxValid), .rxCtl(rxCtl), .rxDeliver(rxDeliver), .rxDiscard(rxDiscard),
	.withdrawAll(withdrawAll), .flushRx(flushRx), .resetActive(resetActive),
	.sendSeqState(sendSeqState), .oldestUnackedState(oldestUnackedState),
	.receiveSeqState(receiveSeqState)
);

// *** multilink_peer_model.sv ***
`timescale 1ns/1ps
module multilink_peer_model (
	input  wire logic	clk,
	input  wire logic	rst_n,
	input  wire logic	mute,
	input  wire logic [3:0]	lag,
	input  wire multilink_reset_control_pkg::tx_frame_t	txFrame,
	input  wire logic	txValid,
	output logic	txTaken,
	output logic	reqXferInd,
	output logic	cfmXferInd,
	output logic [1:0]	cfmXferLink,
	output logic	rxValid,
	output multilink_reset_control_pkg::ctl_field_t	rxCtl
);
	logic [3:0]	lagCnt;
	// channel takes a frame after lag cycles; peer echoes request and confirm
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lagCnt <= 4'h0;
			txTaken <= 1'b0;
			reqXferInd <= 1'b0;
			cfmXferInd <= 1'b0;
			cfmXferLink <= 2'h0;
			rxValid <= 1'b0;
			rxCtl <= '0;
		end else begin
			txTaken <= 1'b0;
			reqXferInd <= 1'b0;
			cfmXferInd <= 1'b0;
			rxValid <= 1'b0;
			rxCtl <= ~rxCtl; // idle field is inverted every cycle, so it holds the last frame every second cycle
			lagCnt <= 4'h0;
			if (txValid && !txTaken) begin
				lagCnt <= lagCnt + 4'h1;
				if (lagCnt >= lag) begin
					txTaken <= 1'b1;
					reqXferInd <= txFrame.ctl.rstReq;
					cfmXferInd <= txFrame.ctl.rstCfm;
					cfmXferLink <= txFrame.link;
					// muted peer models a lost answer, so the timer must act
					rxValid <= !mute && (txFrame.ctl.rstReq || txFrame.ctl.rstCfm);
					rxCtl <= {12'hA5A, 2'h0, txFrame.ctl.rstReq, txFrame.ctl.rstCfm};
				end
			end
		end
	end
endmodule : multilink_peer_model

// *** multilink_reset_control_test.sv ***
`timescale 1ns/1ps
`include "multilink_reset_control_regs.svh"
module multilink_reset_control_test;
	localparam int unsigned TMO = 200;
	logic	clk = 1'b0;
	logic	rst_n = 1'b0;
	logic	startReset = 1'b0;
	logic	pktValid = 1'b0;
	logic	tbRxValid = 1'b0;
	logic	mute = 1'b0;
	logic [3:0]	lag = 4'h0;
	logic	ackValid = 1'b0;
	logic [11:0]	ackOldest = 12'h000;
	logic [3:0]	linkBusy = 4'h0;
	multilink_reset_control_pkg::ctl_field_t	tbRxCtl = '0;
	multilink_reset_control_pkg::ctl_field_t	pRxCtl, rxCtl;
	multilink_reset_control_pkg::tx_frame_t	txFrame;
	logic	pktReady, txValid, txTaken, reqXferInd, cfmXferInd, pRxValid, rxValid;
	logic	rxDeliver, rxDiscard, withdrawAll, flushRx, resetActive, resetDone;
	logic [1:0]	cfmXferLink;
	logic [11:0]	sendSeqState, oldestUnackedState, receiveSeqState;
	int	error_cnt = 0;
	int	n_checks = 0;
	always #25 clk = ~clk;
	// bench frames win over the peer; they never overlap in time
	assign rxValid = pRxValid | tbRxValid;
	assign rxCtl = tbRxValid ? tbRxCtl : pRxCtl;
	multilink_reset_control #(.RST_TMO_CYCLES(TMO)) DUT (
		.clk(clk), .rst_n(rst_n), .startReset(startReset), .pktValid(pktValid),
		.pktReady(pktReady), .txFrame(txFrame), .txValid(txValid), .txTaken(txTaken),
		.reqXferInd(reqXferInd), .cfmXferInd(cfmXferInd), .cfmXferLink(cfmXferLink),
		.ackValid(ackValid), .ackOldest(ackOldest), .linkUp(4'hF), .linkBusy(linkBusy),
		.rxValid(rxValid), .rxCtl(rxCtl), .rxDeliver(rxDeliver), .rxDiscard(rxDiscard),
		.withdrawAll(withdrawAll), .flushRx(flushRx), .resetActive(resetActive),
		.resetDone(resetDone), .sendSeqState(sendSeqState),
		.oldestUnackedState(oldestUnackedState), .receiveSeqState(receiveSeqState));
	multilink_peer_model peer (
		.clk(clk), .rst_n(rst_n), .mute(mute), .lag(lag), .txFrame(txFrame),
		.txValid(txValid), .txTaken(txTaken), .reqXferInd(reqXferInd),
		.cfmXferInd(cfmXferInd), .cfmXferLink(cfmXferLink), .rxValid(pRxValid),
		.rxCtl(pRxCtl));
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick
	// pktReady read at the edge is the value the block sampled
	task automatic sendPkt(output multilink_reset_control_pkg::tx_frame_t f);
		@(posedge clk);
		pktValid <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			if (pktReady === 1'b1) break;
		end
		pktValid <= 1'b0;
		#1;
		chk("txValid", 16'h0001, {15'h0, txValid});
		f = txFrame;
	endtask : sendPkt
	task automatic waitTx(input logic [3:0] fl);
		for (int i = 0; i < 60 && !(txValid === 1'b1 && txFrame.ctl[3:0] === fl); i++) tick();
		chk("txFlags", {11'h0, 1'b1, fl}, {11'h0, txValid, txFrame.ctl[3:0]});
	endtask : waitTx
	task automatic waitDone();
		for (int i = 0; i < 60 && resetDone !== 1'b1; i++) tick();
		chk("doneIdleRecv", 16'h0002, {resetActive, receiveSeqState, 1'b0, resetDone, 1'b0});
	endtask : waitDone
	task automatic rxSend(input logic [15:0] c, input logic [1:0] exp);
		@(posedge clk);
		tbRxValid <= 1'b1;
		tbRxCtl <= c;
		@(posedge clk);
		tbRxValid <= 1'b0;
		tbRxCtl <= ~c;
		#1;
		chk("deliverDiscard", {14'h0, exp}, {14'h0, rxDeliver, rxDiscard});
	endtask : rxSend
	task automatic testPkt();
		multilink_reset_control_pkg::tx_frame_t f;
		sendPkt(f);
		chk("ctl0", 16'h0000, f.ctl);
		sendPkt(f);
		chk("ctl1", 16'h0010, f.ctl);
		tick();
		chk("sendSeq", 16'h0002, {4'h0, sendSeqState});
		@(posedge clk);
		ackValid <= 1'b1;
		ackOldest <= 12'h002;
		@(posedge clk);
		ackValid <= 1'b0;
		#1;
		chk("oldest", 16'h0002, {4'h0, oldestUnackedState});
		$display("testPkt finished");
	endtask : testPkt
	task automatic testRx();
		rxSend(16'h0000, 2'b10);
		rxSend(16'h0060, 2'b01);
		rxSend(16'h0013, 2'b01);
		rxSend(16'h0011, 2'b01);
		tick();
		chk("recvSeq", 16'h0001, {4'h0, receiveSeqState});
		$display("testRx finished");
	endtask : testRx
	task automatic testReset();
		multilink_reset_control_pkg::tx_frame_t f;
		logic [1:0] cl;
		@(posedge clk);
		startReset <= 1'b1;
		lag <= 4'h3;
		@(posedge clk);
		startReset <= 1'b0;
		#1;
		chk("withdraw", 16'h0003, {14'h0, withdrawAll, resetActive});
		chk("sendOldest", 16'h0000, {4'h0, sendSeqState | oldestUnackedState});
		waitTx(4'h2);
		waitTx(4'h1);
		cl = txFrame.link;
		waitDone();
		sendPkt(f);
		chk("firstCtl", 16'h0000, f.ctl);
		chk("firstLink", {14'h0, cl}, {14'h0, f.link});
		$display("testReset finished");
	endtask : testReset
	task automatic testTimeout();
		int i;
		@(posedge clk);
		mute <= 1'b1;
		lag <= 4'h5;
		startReset <= 1'b1;
		@(posedge clk);
		startReset <= 1'b0;
		waitTx(4'h2);
		for (i = 0; i < TMO + 60 && withdrawAll !== 1'b1; i++) tick();
		chk("tmoRestart", 16'h0001, {15'h0, withdrawAll});
		chk("tmoNotEarly", 16'h0001, {15'h0, i >= TMO});
		@(posedge clk);
		mute <= 1'b0;
		waitTx(4'h2);
		waitDone();
		$display("testTimeout finished");
	endtask : testTimeout
	// peer asks first; a second request after our confirm restarts everything
	task automatic testPeerReq();
		@(posedge clk);
		mute <= 1'b1;
		rxSend(16'h0000, 2'b10);
		rxSend(16'h07F2, 2'b00);
		chk("peerStart", 16'h0007, {13'h0, withdrawAll, flushRx, resetActive});
		chk("recvZero", 16'h0000, {4'h0, receiveSeqState});
		rxSend(16'h0000, 2'b01);
		rxSend(16'h0002, 2'b01);
		waitTx(4'h1);
		for (int i = 0; i < 20 && txValid === 1'b1; i++) tick();
		chk("cfmOnlyBusy", 16'h0001, {15'h0, resetActive});
		rxSend(16'h0002, 2'b00);
		chk("newReqRestart", 16'h0003, {14'h0, withdrawAll, flushRx});
		@(posedge clk);
		mute <= 1'b0;
		waitDone();
		$display("testPeerReq finished");
	endtask : testPeerReq
	// stray confirm forces a resend; busy request link moves the confirm
	task automatic testRetry();
		logic [1:0] rl;
		@(posedge clk);
		mute <= 1'b1;
		startReset <= 1'b1;
		@(posedge clk);
		startReset <= 1'b0;
		waitTx(4'h2);
		for (int i = 0; i < 20 && txValid === 1'b1; i++) tick();
		@(posedge clk);
		mute <= 1'b0;
		rxSend(16'h0001, 2'b00);
		waitTx(4'h2);
		rl = txFrame.link;
		for (int i = 0; i < 20 && txValid === 1'b1; i++) tick();
		@(posedge clk);
		linkBusy <= 4'h1 << rl;
		waitTx(4'h1);
		chk("cfmOtherLink", 16'h0001, {15'h0, txFrame.link != rl});
		waitDone();
		@(posedge clk);
		linkBusy <= 4'h0;
		$display("testRetry finished");
	endtask : testRetry
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		testPkt();
		testRx();
		testReset();
		testTimeout();
		testPeerReq();
		testRetry();
		test_done();
	end
	// whole run is about four hundred cycles; the watchdog allows 4000, ten times that
	initial begin
		#200000;
		error_cnt++;
		$display("[ERR] watchdog expected finish seen hang");
		test_done();
	end
endmodule : multilink_reset_control_test
